// [core/flash_host.sv]
// Local design decisions: the register offsets and the AXI4-Lite register port.
module flash_host (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Flash pins
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_byte_n,
  output logic [18:0] flash_addr,
  output logic [15:0] flash_dq_o,
  output logic [15:0] flash_dq_oe,
  input wire logic [15:0] flash_dq_i
);
  import flash_pkg::*;
  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT, S_SETTLE} sstate_t;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Which flash bus cycle a given step of an operation issues
  function automatic cyc_t step_cycle(input op_t op, input logic [2:0] step,
      input logic bm, input logic [19:0] a, input logic [15:0] d);
    cyc_t c;
    logic [19:0] u1;
    logic [19:0] u2;
    u1 = bm ? UNLOCK1_BYTE : UNLOCK1_WORD;
    u2 = bm ? UNLOCK2_BYTE : UNLOCK2_WORD;
    c = '{wr: 1'b0, addr: a, data: d, last: 1'b0};
    case (op)
      OP_READ: c.last = 1'b1;
      OP_RESET: c = '{wr: 1'b1, addr: u1, data: {8'h00, CMD_RESET},
                      last: 1'b1};
      default: begin
        case (step)
          3'h0: c = '{wr: 1'b1, addr: u1, data: {8'h00, UNLOCK1_DATA},
                      last: 1'b0};
          3'h1: c = '{wr: 1'b1, addr: u2, data: {8'h00, UNLOCK2_DATA},
                      last: 1'b0};
          3'h2: c = '{wr: 1'b1, addr: u1, last: 1'b0,
                      data: {8'h00, (op == OP_AUTOSEL) ? CMD_AUTOSEL
                                                       : CMD_PROGRAM}};
          3'h3: begin
            // Auto-select reads the code; program writes the target word
            c.wr = (op == OP_PROGRAM);
            c.last = (op == OP_AUTOSEL);
          end
          default: c.last = 1'b1;
        endcase
      end
    endcase
    return c;
  endfunction : step_cycle

  cycle_if cyc();
  cyc_t cur;
  logic busy, start;
  op_t start_op;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata, m;
  logic byte_mode, next_byte_mode;
  logic [19:0] addr_reg, next_addr_reg;
  logic [15:0] wdata_reg, next_wdata_reg;
  sstate_t state, next_state;
  op_t op, next_op;
  logic [2:0] step, next_step;
  logic err_seen, next_err_seen, fail, next_fail, toggle, next_toggle;
  logic [15:0] rd_result, next_rd_result;
  logic [10:0] settle_cnt, next_settle_cnt;

  assign busy = (state != S_IDLE);
  // Frozen bus looks idle so no handshake slips through
  assign s_axi_awready = clk_en && !aw_held && !bvalid;
  assign s_axi_wready = clk_en && !w_held && !bvalid;
  assign s_axi_bvalid = clk_en && bvalid;
  assign s_axi_arready = clk_en && !rvalid;
  assign s_axi_rvalid = clk_en && rvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign flash_byte_n = !byte_mode;

  // ==========================================================
  // Register slave
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    next_byte_mode = byte_mode;
    next_addr_reg = addr_reg;
    next_wdata_reg = wdata_reg;
    start = 1'b0;
    start_op = OP_READ;
    m = 32'h00000000;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      // Setup registers are locked while an operation runs
      if (busy || !(aw_addr == REG_CTRL || aw_addr == REG_ADDR
                    || aw_addr == REG_WDATA)) begin
        next_bresp = RESP_SLVERR;
      end else if (aw_addr == REG_CTRL) begin
        m = merge({27'h0, byte_mode, 2'h0, op}, w_data, w_strb);
        next_byte_mode = m[CTRL_BYTE_BIT];
        start_op = op_t'(m[1:0]);
        start = 1'b1;
      end else if (aw_addr == REG_ADDR) begin
        m = merge({12'h000, addr_reg}, w_data, w_strb);
        next_addr_reg = m[19:0];
      end else begin
        m = merge({16'h0000, wdata_reg}, w_data, w_strb);
        next_wdata_reg = m[15:0];
      end
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL: next_rdata = {27'h0, byte_mode, 2'h0, op};
        REG_ADDR: next_rdata = {12'h000, addr_reg};
        REG_WDATA: next_rdata = {16'h0000, wdata_reg};
        REG_STATUS: next_rdata = {29'h0, toggle, fail, busy};
        REG_RDATA: next_rdata = {16'h0000, rd_result};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h00000000;
      byte_mode <= CTRL_BYTE_RESET;
      addr_reg <= ADDR_RESET;
      wdata_reg <= DATA_RESET;
    end else if (clk_en) begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      byte_mode <= next_byte_mode;
      addr_reg <= next_addr_reg;
      wdata_reg <= next_wdata_reg;
    end
  end

  // ==========================================================
  // Command sequencer
  assign cur = step_cycle(op, step, byte_mode, addr_reg, wdata_reg);
  assign cyc.req = (state == S_ISSUE);
  assign cyc.wr = cur.wr;
  assign cyc.addr = cur.addr;
  assign cyc.wdata = cur.data;
  assign cyc.byte_mode = byte_mode;

  always_comb begin
    next_state = state;
    next_op = op;
    next_step = step;
    next_err_seen = err_seen;
    next_fail = fail;
    next_toggle = toggle;
    next_rd_result = rd_result;
    next_settle_cnt = settle_cnt;
    case (state)
      S_IDLE: begin
        if (start) begin
          next_op = start_op;
          next_step = 3'h0;
          next_err_seen = 1'b0;
          next_fail = 1'b0;
          next_state = S_ISSUE;
        end
      end
      S_ISSUE: next_state = S_WAIT;
      S_WAIT: begin
        if (cyc.done) begin
          if (!cur.last) begin
            next_step = step + 3'h1;
            next_state = S_ISSUE;
          end else if (op == OP_RESET) begin
            next_settle_cnt = 11'(RESET_WAIT_CYCLES - 1);
            next_state = S_SETTLE;
          end else if (op == OP_PROGRAM) begin
            next_rd_result = cyc.rdata;
            next_toggle = cyc.rdata[TOGGLE_BIT];
            // Polling bit matches written data once the word is in
            if (cyc.rdata[POLLING_BIT] == wdata_reg[POLLING_BIT]) begin
              next_state = S_IDLE;
            end else if (err_seen) begin
              next_fail = 1'b1;
              next_state = S_IDLE;
            end else begin
              // Error bit may rise just before completion: poll once more
              next_err_seen = cyc.rdata[ERROR_BIT];
              next_state = S_ISSUE;
            end
          end else begin
            next_rd_result = cyc.rdata;
            next_state = S_IDLE;
          end
        end
      end
      S_SETTLE: begin
        if (settle_cnt == 11'h000) begin
          next_state = S_IDLE;
        end else begin
          next_settle_cnt = settle_cnt - 11'h001;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= S_IDLE;
      op <= OP_READ;
      step <= 3'h0;
      err_seen <= 1'b0;
      fail <= 1'b0;
      toggle <= 1'b0;
      rd_result <= DATA_RESET;
      settle_cnt <= 11'h000;
    end else if (clk_en) begin
      state <= next_state;
      op <= next_op;
      step <= next_step;
      err_seen <= next_err_seen;
      fail <= next_fail;
      toggle <= next_toggle;
      rd_result <= next_rd_result;
      settle_cnt <= next_settle_cnt;
    end
  end

  flash_cycle u_cycle (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .cyc(cyc),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n),
    .flash_addr(flash_addr),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_i(flash_dq_i)
  );

  chk_unlock_first: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cyc.req && step == 3'h0 && (op == OP_AUTOSEL || op == OP_PROGRAM)
    |-> cyc.wr && cyc.wdata[7:0] == UNLOCK1_DATA
        && cyc.addr == (byte_mode ? UNLOCK1_BYTE : UNLOCK1_WORD))
    else $error("first unlock cycle wrong");
  chk_unlock_second: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cyc.req && step == 3'h1 && op != OP_READ && op != OP_RESET
    |-> cyc.wr && cyc.wdata[7:0] == UNLOCK2_DATA
        && cyc.addr == (byte_mode ? UNLOCK2_BYTE : UNLOCK2_WORD))
    else $error("second unlock cycle wrong");
  chk_autosel_cmd: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cyc.req && step == 3'h2 && op == OP_AUTOSEL
    |-> cyc.wr && cyc.wdata[7:0] == CMD_AUTOSEL
        && cyc.addr == (byte_mode ? UNLOCK1_BYTE : UNLOCK1_WORD))
    else $error("auto-select command wrong");
  chk_program_done: assert property (
    @(posedge aclk) disable iff (!aresetn)
    clk_en && state == S_WAIT && op == OP_PROGRAM && step == 3'h4
    && cyc.done && cyc.rdata[POLLING_BIT] == wdata_reg[POLLING_BIT]
    |=> state == S_IDLE && !fail && rd_result == $past(cyc.rdata))
    else $error("program completion missed");
  chk_reset_settle: assert property (
    @(posedge aclk) disable iff (!aresetn)
    clk_en && state == S_WAIT && op == OP_RESET && cyc.done
    |=> state == S_SETTLE && settle_cnt == 11'(RESET_WAIT_CYCLES - 1))
    else $error("reset settle wait not started");
  chk_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while pending");
endmodule : flash_host

// [core/flash_pkg.sv]
package flash_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_NS = 8;
  localparam int CLK_MHZ = 125;
  localparam int SYNC_STAGES = 2;
  localparam int T_SETUP_NS = 10;
  localparam int T_ACC_NS = 90;
  localparam int T_WP_NS = 50;
  localparam int T_HOLD_NS = 10;
  localparam int T_RESET_WAIT_US = 10;
  localparam int SETUP_CYCLES = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYCLES = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  // Access time plus the input synchroniser latency
  localparam int RD_CYCLES = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
  localparam int HOLD_CYCLES = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_WAIT_CYCLES = T_RESET_WAIT_US * CLK_MHZ;
  // ==========================================================
  // Command set
  localparam logic [19:0] UNLOCK1_BYTE = 20'h0AAAA;
  localparam logic [19:0] UNLOCK1_WORD = 20'h05555;
  localparam logic [19:0] UNLOCK2_BYTE = 20'h00555;
  localparam logic [19:0] UNLOCK2_WORD = 20'h02AAA;
  localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam int POLLING_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int ERROR_BIT = 5;
  // ==========================================================
  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam int CTRL_BYTE_BIT = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_FAIL_BIT = 1;
  localparam int STAT_TOGGLE_BIT = 2;
  localparam logic CTRL_BYTE_RESET = 1'b0;
  localparam logic [19:0] ADDR_RESET = 20'h00000;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {OP_READ, OP_RESET, OP_AUTOSEL, OP_PROGRAM} op_t;
  typedef struct packed {
    logic wr;
    logic [19:0] addr;
    logic [15:0] data;
    logic last;
  } cyc_t;
endpackage : flash_pkg

// [core/cycle_if.sv]
interface cycle_if;
  logic req;
  logic wr;
  logic byte_mode;
  logic [19:0] addr;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport initiator(output req, wr, byte_mode, addr, wdata,
                    input done, rdata);
  modport target(input req, wr, byte_mode, addr, wdata,
                 output done, rdata);
endinterface : cycle_if

// [core/flash_cycle.sv]
module flash_cycle (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // Sequencer side
  cycle_if.target cyc,
  // Flash pins
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [18:0] flash_addr,
  output logic [15:0] flash_dq_o,
  output logic [15:0] flash_dq_oe,
  input wire logic [15:0] flash_dq_i
);
  import flash_pkg::*;
  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} cstate_t;
  cstate_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic wr, next_wr, byte_mode, next_byte_mode, done, next_done;
  logic next_ce_n, next_oe_n, next_we_n;
  logic [18:0] next_addr;
  logic [15:0] next_dq_o, next_dq_oe, rdata, next_rdata;
  logic [15:0] dq_meta, dq_sync;

  // ==========================================================
  // Pin input synchroniser
  always_ff @(posedge aclk) begin
    if (clk_en) begin
      dq_meta <= flash_dq_i;
      dq_sync <= dq_meta;
    end
  end

  // ==========================================================
  // Bus cycle timing
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_wr = wr;
    next_byte_mode = byte_mode;
    next_done = 1'b0;
    next_ce_n = flash_ce_n;
    next_oe_n = flash_oe_n;
    next_we_n = flash_we_n;
    next_addr = flash_addr;
    next_dq_o = flash_dq_o;
    next_dq_oe = flash_dq_oe;
    next_rdata = rdata;
    if (cnt != 4'h0) begin
      next_cnt = cnt - 4'h1;
    end
    case (state)
      C_IDLE: begin
        if (cyc.req) begin
          next_wr = cyc.wr;
          next_byte_mode = cyc.byte_mode;
          next_ce_n = 1'b0;
          // Byte mode: A-1 rides on the top data pin, upper lanes float
          if (cyc.byte_mode) begin
            next_addr = cyc.addr[19:1];
            next_dq_o = {cyc.addr[0], 7'h00, cyc.wdata[7:0]};
            next_dq_oe = cyc.wr ? 16'h80FF : 16'h8000;
          end else begin
            next_addr = cyc.addr[18:0];
            next_dq_o = cyc.wdata;
            next_dq_oe = cyc.wr ? 16'hFFFF : 16'h0000;
          end
          next_cnt = 4'(SETUP_CYCLES - 1);
          next_state = C_SETUP;
        end
      end
      C_SETUP: begin
        if (cnt == 4'h0) begin
          next_we_n = !wr;
          next_oe_n = wr;
          next_cnt = wr ? 4'(WP_CYCLES - 1) : 4'(RD_CYCLES - 1);
          next_state = C_STROBE;
        end
      end
      C_STROBE: begin
        if (cnt == 4'h0) begin
          if (!wr) begin
            next_rdata = byte_mode ? {8'h00, dq_sync[7:0]} : dq_sync;
          end
          // Address and data stay put past the rising strobe edge
          next_we_n = 1'b1;
          next_oe_n = 1'b1;
          next_cnt = 4'(HOLD_CYCLES - 1);
          next_state = C_HOLD;
        end
      end
      C_HOLD: begin
        if (cnt == 4'h0) begin
          next_ce_n = 1'b1;
          next_dq_oe = 16'h0000;
          next_done = 1'b1;
          next_state = C_IDLE;
        end
      end
      default: next_state = C_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= C_IDLE;
      cnt <= 4'h0;
      wr <= 1'b0;
      byte_mode <= 1'b0;
      done <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_addr <= 19'h00000;
      flash_dq_o <= 16'h0000;
      flash_dq_oe <= 16'h0000;
      rdata <= 16'h0000;
    end else if (clk_en) begin
      state <= next_state;
      cnt <= next_cnt;
      wr <= next_wr;
      byte_mode <= next_byte_mode;
      done <= next_done;
      flash_ce_n <= next_ce_n;
      flash_oe_n <= next_oe_n;
      flash_we_n <= next_we_n;
      flash_addr <= next_addr;
      flash_dq_o <= next_dq_o;
      flash_dq_oe <= next_dq_oe;
      rdata <= next_rdata;
    end
  end

  assign cyc.done = done;
  assign cyc.rdata = rdata;

  chk_strobe_exclusive: assert property (@(posedge aclk) disable iff (!aresetn)
    !(!flash_we_n && !flash_oe_n))
    else $error("write and output strobes low together");
  chk_write_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(flash_we_n) |-> (!flash_we_n && !flash_ce_n) [*7])
    else $error("write strobe pulse too short");
  chk_addr_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    !flash_ce_n && $past(!flash_ce_n) |-> $stable(flash_addr))
    else $error("address moved during a bus cycle");
endmodule : flash_cycle

// [bench/flash_model.sv]
module flash_model #(
  parameter logic [15:0] MAKER = 16'h00C3, // Arbitrary identity value
  parameter logic [15:0] DEVICE = 16'h00B4 // Arbitrary identity value
) (
  // Flash pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic byte_n,
  input wire logic [18:0] addr,
  input wire logic [15:0] dq_o,
  input wire logic [15:0] dq_oe,
  output logic [15:0] dq_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [19:0] ba, la;
  logic [15:0] mem [16];
  logic [15:0] q, dp, u1, u2;
  logic [1:0] st;
  logic asel, busy, err, tog;
  int polls;
  // Byte mode rebuilds A-1 from the shared data pin
  assign ba = byte_n ? {1'b0, addr} : {addr, dq_o[15]};
  assign u1 = byte_n ? 16'h5555 : 16'hAAAA;
  assign u2 = byte_n ? 16'h2AAA : 16'h0555;
  // Released bus shows the inverse, never a stale copy
  assign dq_i = (dq_oe & dq_o) | (~dq_oe & (!ce_n && !oe_n ? q : ~q));
  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    {st, asel, busy, err, tog, q, polls} = '0;
  end
  always @(negedge we_n) if (!ce_n) la = ba;
  always @(posedge we_n) if (!ce_n) begin
    // Fourth program write is data, even when it looks like F0h
    if (st == 2'd3 && !busy) begin
      dp = dq_o;
      err = |(~mem[la[3:0]] & dp);
      mem[la[3:0]] = mem[la[3:0]] & dp;
      busy = 1'b1;
      polls = 3;
      st = 2'd0;
    end else if (dq_o[7:0] == 8'hF0 && (!busy || err)) begin
      {st, asel, busy, err} = '0;
    end else if (busy) begin
      st = 2'd0;
    end else if (st == 0 && la[15:0] == u1 && dq_o[7:0] == 8'hAA) begin
      st = 2'd1;
    end else if (st == 1 && la[15:0] == u2 && dq_o[7:0] == 8'h55) begin
      st = 2'd2;
    end else if (st == 2 && la[15:0] == u1 && dq_o[7:0] == 8'h90) begin
      asel = 1'b1;
      st = 2'd0;
    end else if (st == 2 && la[15:0] == u1 && dq_o[7:0] == 8'hA0) begin
      st = 2'd3;
    end else begin
      {st, asel} = '0;
    end
  end
  // ====================================
  // Reads: status while busy, else identity or array
  always @(negedge oe_n) if (!ce_n) begin
    if (busy) begin
      q = {8'h00, ~dp[7], tog, err, 5'h00};
      tog = ~tog;
      polls = polls - 1;
      if (polls == 0 && !err) busy = 1'b0;
    end else if (asel) begin
      case (addr[1:0])
        2'd0: q = MAKER;
        2'd1: q = DEVICE;
        2'd2: q = {15'h0000, addr[12]};
        default: q = 16'h0000;
      endcase
    end else begin
      q = mem[ba[3:0]];
    end
  end
endmodule : flash_model

// [bench/flash_command_unlock_program_tb.sv]
module flash_command_unlock_program_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_pkg::*;
  localparam logic [15:0] MAKER = 16'h00C3; // Arbitrary identity value
  localparam logic [15:0] DEVICE = 16'h00B4; // Arbitrary identity value
  logic aclk, aresetn, ce_n, oe_n, we_n, byte_n, e, clk_en;
  logic [3:0] s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, stat;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [18:0] fa;
  logic [19:0] a;
  logic [15:0] dq_o, dq_oe, dq_i, w, exp_mem [16];
  int error_cnt, check_count;
  flash_host i_flash_host (.aclk, .aresetn, .clk_en,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_byte_n(byte_n), .flash_addr(fa),
    .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_i));
  flash_model #(.MAKER(MAKER), .DEVICE(DEVICE)) i_flash_model (.ce_n,
    .oe_n, .we_n, .byte_n, .addr(fa), .dq_o, .dq_oe, .dq_i);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // ====================================
  // Bus and checking tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 4000) begin
      error_cnt++;
      summarize();
    end
  endtask : tick
  // Starts one edge late so a strobe is never driven twice in one step
  task automatic axw(input logic [7:0] ad, input logic [31:0] v);
    int n;
    logic ah, wh;
    {n, ah, wh} = '0;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(ah && wh)) begin
      tick(n);
      if (!ah && s_axi_awready) begin
        ah = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wh && s_axi_wready) begin
        wh = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do tick(n); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] ad, output logic [31:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= ad;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do tick(n); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do tick(n); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr
  task automatic idle();
    int n;
    n = 0;
    do begin
      tick(n);
      // Random freezes stretch flash cycles in flight
      clk_en <= 1'b0;
      repeat (1 + $urandom_range(2)) tick(n);
      clk_en <= 1'b1;
      axr(REG_STATUS, stat);
    end while (stat[STAT_BUSY_BIT] !== 1'b0);
    axr(REG_RDATA, rd);
  endtask : idle
  task automatic run(input logic [1:0] op, input logic bm,
      input logic [19:0] ad, input logic [15:0] v);
    axw(REG_ADDR, {12'h000, ad});
    axw(REG_WDATA, {16'h0000, v});
    axw(REG_CTRL, {27'h0, bm, 2'b00, op});
    idle();
  endtask : run
  // ====================================
  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
      s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    foreach (exp_mem[i]) exp_mem[i] = 16'hFFFF;
    {clk_en, s_axi_wstrb} = 5'h1F;
    void'($urandom(32'h9E6D));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      axr(i == 0 ? REG_CTRL : i == 1 ? REG_ADDR : REG_WDATA, rd);
      check(rd, 32'h0);
    end
    axr(8'h20, rd);
    check(rsp, RESP_SLVERR);
    axw(REG_STATUS, 32'h1);
    check(rsp, RESP_SLVERR);
    axw(REG_WDATA, 32'h1234);
    s_axi_wstrb <= 4'h1;
    axw(REG_WDATA, 32'hABCD);
    s_axi_wstrb <= 4'hF;
    axr(REG_WDATA, rd);
    check(rd, 32'h12CD);
    $display("test registers done");
    run(2'd2, 1'b0, 20'h00000, 16'h0);
    check(rd, MAKER);
    run(2'd2, 1'b0, 20'h00001, 16'h0);
    check(rd, DEVICE);
    run(2'd2, 1'b0, 20'h01002, 16'h0);
    check(rd, 32'h1);
    run(2'd2, 1'b0, 20'h00002, 16'h0);
    check(rd, 32'h0);
    run(2'd2, 1'b1, 20'h00002, 16'h0);
    check(rd, {24'h0, DEVICE[7:0]});
    run(2'd2, 1'b1, 20'hF0000, 16'h0);
    check(rd, {24'h0, MAKER[7:0]});
    axw(REG_CTRL, 32'h1);
    axw(REG_ADDR, 32'h5);
    check(rsp, RESP_SLVERR);
    idle();
    run(2'd0, 1'b0, 20'h00000, 16'h0);
    check(rd, 32'hFFFF);
    $display("test identity done");
    for (int i = 0; i < 10; i++) begin
      a = i < 2 ? 20'h3 : 20'($urandom_range(15));
      w = i == 0 ? 16'h0F0F : i == 1 ? 16'hFF80 : 16'($urandom);
      e = |(~exp_mem[a[3:0]] & w);
      exp_mem[a[3:0]] = exp_mem[a[3:0]] & w;
      run(2'd3, 1'b0, a, w);
      check(stat[STAT_FAIL_BIT], e);
      if (e) begin
        run(2'd1, 1'b0, 20'h0, 16'h0);
        check(stat[STAT_FAIL_BIT], 1'b0);
      end else begin
        check(stat[STAT_TOGGLE_BIT], w[6]);
      end
      run(2'd0, 1'b0, a, 16'h0);
      check(rd, exp_mem[a[3:0]]);
    end
    $display("test program done");
    summarize();
  end
endmodule : flash_command_unlock_program_tb
